// *** serial_pkg.sv ***
// constants for the dual mode serial channel
package serial_pkg;
  // byte addresses of the nibble registers
  localparam logic [15:0] ADDR_MODE     = 16'hFF70;
  localparam logic [15:0] ADDR_PARCLK   = 16'hFF71;
  localparam logic [15:0] ADDR_TRIG     = 16'hFF72;
  localparam logic [15:0] ADDR_ERR      = 16'hFF73;
  localparam logic [15:0] ADDR_DATALO   = 16'hFF74;
  localparam logic [15:0] ADDR_DATAHI   = 16'hFF75;
  localparam logic [15:0] ADDR_TEST     = 16'hFF76;
  localparam logic [15:0] ADDR_IMASK    = 16'hFFE3;
  localparam logic [15:0] ADDR_IFLAG    = 16'hFFF3;
  // field positions
  localparam int BIT_PINEN   = 0;
  localparam int BIT_MODELO  = 1;
  localparam int BIT_PARSNS  = 2;
  localparam int BIT_PAREN   = 3;
  localparam int BIT_TRANSMIT_ENABLE    = 0;
  localparam int BIT_TRANSMIT_TRIGGER   = 1;
  localparam int BIT_RECEIVE_ENABLE    = 2;
  localparam int BIT_RECEIVE_TRIGGER   = 3;
  localparam int BIT_OVR     = 0;
  localparam int BIT_PAR     = 1;
  localparam int BIT_FRM     = 2;
  localparam int BIT_RXDONE  = 0;
  localparam int BIT_TXDONE  = 1;
  localparam int BIT_ERREV   = 2;
  // reset values
  localparam logic [3:0] RST_NIBBLE = 4'h0;
  // modes
  localparam logic [1:0] MODE_MASTER = 2'h0;
  localparam logic [1:0] MODE_SLAVE  = 2'h1;
  localparam logic [1:0] MODE_ASYNC7 = 2'h2;
  localparam logic [1:0] MODE_ASYNC8 = 2'h3;
  // bit rates and derived half-bit counts at 25 MHz
  localparam int CLK_HZ   = 25000000;
  localparam int RATE_0   = 1200;
  localparam int RATE_1   = 600;
  localparam int RATE_2   = 2400;
  localparam int HALF_0   = CLK_HZ / (2 * RATE_0);
  localparam int HALF_1   = CLK_HZ / (2 * RATE_1);
  localparam int HALF_2   = CLK_HZ / (2 * RATE_2);
  // timer source: half a bit is one timer tick
  localparam int HALF_TMR = 1;
  localparam int BITS_MAX = 11;
endpackage : serial_pkg

// *** dual_mode_serial_interface.sv ***
// dual mode serial channel with nibble registers on an axi4-lite slave
`timescale 1ns/1ps
module dual_mode_serial_interface
  import serial_pkg::*;
(
  input  wire logic        clk,           // core clock
  input  wire logic        rst_n,         // async reset, active low
  input  wire logic [15:0] s_axi_awaddr,  // write address
  input  wire logic        s_axi_awvalid, // write address valid
  output logic             s_axi_awready, // write address ready
  input  wire logic [31:0] s_axi_wdata,   // write data
  input  wire logic [3:0]  s_axi_wstrb,   // write strobes
  input  wire logic        s_axi_wvalid,  // write data valid
  output logic             s_axi_wready,  // write data ready
  output logic [1:0]       s_axi_bresp,   // write response
  output logic             s_axi_bvalid,  // write response valid
  input  wire logic        s_axi_bready,  // write response ready
  input  wire logic [15:0] s_axi_araddr,  // read address
  input  wire logic        s_axi_arvalid, // read address valid
  output logic             s_axi_arready, // read address ready
  output logic [31:0]      s_axi_rdata,   // read data
  output logic [1:0]       s_axi_rresp,   // read response
  output logic             s_axi_rvalid,  // read data valid
  input  wire logic        s_axi_rready,  // read data ready
  input  wire logic        timerRate,     // programmable timer rate tick
  input  wire logic        serialIn,      // serial data in pin
  output logic             serialOut,     // serial data out
  output logic             serialOutOe_n, // data out enable, low drives
  input  wire logic        sclkIn,        // external serial clock in
  output logic             sclkOut,       // master serial clock out
  output logic             sclkOe_n,      // clock enable, low drives
  output logic             pinsSerial,    // port pins owned by serial
  output logic             irq            // level interrupt
);
  typedef enum {IDLE, START, DATA, PARITY, STOP} phase_e;

  typedef struct packed {
    logic        awHeld, wHeld, bvalid, rvalid;
    logic [15:0] awAddr;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic [31:0] rdata;
    logic        rErr, bErr;
    logic [3:0]  modeReg, parClk, errs, iflag, imask;
    logic        testBit, transmit_enable, receive_enable, txRun, rxRun, rxUnread;
    logic [7:0]  data;
    phase_e      txPh, rxPh;
    logic [3:0]  txCnt, rxCnt;
    logic [7:0]  txSh, rxSh;
    logic [19:0] txTmr, rxTmr;
    logic        txHalf, txPar, rxPar;
    logic        sin1, sin2, sck1, sck2, sckD, tmr1, tmr2, tmrD;
    logic        sout, sclk;
  } state_s;

  state_s st, nx;

  // half bit period for the selected rate: clock cycles for codes 0 to 2, timer ticks for code 3
  function automatic logic [19:0] halfCount(input logic [1:0] sel);
    case (sel)
      2'h0:    halfCount = 20'(HALF_0);
      2'h1:    halfCount = 20'(HALF_1);
      2'h2:    halfCount = 20'(HALF_2);
      2'h3:    halfCount = 20'(HALF_TMR);
      default: halfCount = 20'(HALF_0);
    endcase
  endfunction : halfCount

  // register address decode
  function automatic logic isMapped(input logic [15:0] a);
    isMapped = (a == ADDR_MODE) || (a == ADDR_PARCLK) || (a == ADDR_TRIG) ||
               (a == ADDR_ERR) || (a == ADDR_DATALO) || (a == ADDR_DATAHI) ||
               (a == ADDR_TEST) || (a == ADDR_IMASK) || (a == ADDR_IFLAG);
  endfunction : isMapped

  logic [1:0] mode;
  logic       asyncMode, bitCount8, rateTick, tmrTick, sckRise, sckFall, rxTick;
  logic       doWr, wrLane;
  logic [3:0] wrNib;
  logic       rxDone, txDone, frmEv, parEv, ovrEv;

  assign mode      = {st.modeReg[3:2] == 2'h0 ? st.modeReg[2] : st.modeReg[2],
                      st.modeReg[BIT_MODELO]};
  assign asyncMode = mode[1];

  // handshake outputs from state
  assign s_axi_awready = !st.awHeld;
  assign s_axi_wready  = !st.wHeld;
  assign s_axi_bvalid  = st.bvalid;
  assign s_axi_bresp   = st.bErr ? 2'h2 : 2'h0;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_rvalid  = st.rvalid;
  assign s_axi_rdata   = st.rdata;
  assign s_axi_rresp   = st.rErr ? 2'h2 : 2'h0;
  assign pinsSerial    = st.modeReg[BIT_PINEN];
  assign serialOut     = st.sout;
  assign serialOutOe_n = !st.modeReg[BIT_PINEN];
  assign sclkOut       = st.sclk;
  assign sclkOe_n      = !(st.modeReg[BIT_PINEN] && mode == MODE_MASTER);
  assign irq           = |(st.iflag[2:0] & st.imask[2:0]);

  always_comb begin
    nx = st;
    // synchronisers for pins and timer tick
    nx.sin1 = serialIn;
    nx.sin2 = st.sin1;
    nx.sck1 = sclkIn;
    nx.sck2 = st.sck1;
    nx.sckD = st.sck2;
    nx.tmr1 = timerRate;
    nx.tmr2 = st.tmr1;
    nx.tmrD = st.tmr2;
    tmrTick = st.tmr2 && !st.tmrD;
    sckRise = st.sck2 && !st.sckD;
    sckFall = !st.sck2 && st.sckD;
    bitCount8 = (mode != MODE_ASYNC7);
    rxDone = 1'b0;
    txDone = 1'b0;
    frmEv  = 1'b0;
    parEv  = 1'b0;
    ovrEv  = 1'b0;
    rateTick = 1'b0;
    // write channel capture
    if (s_axi_awvalid && !st.awHeld) begin
      nx.awHeld = 1'b1;
      nx.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st.wHeld) begin
      nx.wHeld = 1'b1;
      nx.wData = s_axi_wdata;
      nx.wStrb = s_axi_wstrb;
    end
    doWr   = st.awHeld && st.wHeld && !st.bvalid;
    wrLane = st.wStrb[st.awAddr[1:0]];
    wrNib  = st.wData[{st.awAddr[1:0], 3'h0} +: 4];
    if (st.bvalid && s_axi_bready) begin
      nx.bvalid = 1'b0;
    end
    // transmit side bit timer; the rate source
    if (st.txTmr == 20'h0) begin
      nx.txTmr = halfCount(st.parClk[1:0]) - 20'h1;
    end else begin
      nx.txTmr = st.txTmr - 20'h1;
    end
    rateTick = (st.parClk[1:0] == 2'h3) ? tmrTick : (st.txTmr == 20'h0);
    // transmitter
    if (st.txRun) begin
      if (mode == MODE_SLAVE ? sckFall : rateTick) begin
        nx.txHalf = !st.txHalf;
        if (mode == MODE_MASTER) begin
          nx.sclk = st.txHalf;
        end
        // a bit lasts two half-bit ticks, except on slave clock edges
        if (!st.txHalf || mode == MODE_SLAVE) begin
          case (st.txPh)
            START: begin
              nx.sout = asyncMode ? 1'b0 : st.txSh[0];
              nx.txPh = DATA;
              nx.txCnt = 4'h0;
              nx.txPar = st.parClk[BIT_PARSNS];
              if (!asyncMode) begin
                nx.txSh = {1'b0, st.txSh[7:1]};
                nx.txCnt = 4'h1;
              end
            end
            DATA: begin
              if (st.txCnt == (bitCount8 ? 4'h8 : 4'h7)) begin
                nx.txPh = !asyncMode ? IDLE :
                          (st.parClk[BIT_PAREN] ? PARITY : STOP);
                nx.sout = st.parClk[BIT_PAREN] && asyncMode ? st.txPar : 1'b1;
                if (!asyncMode) begin
                  nx.txRun = 1'b0;
                  txDone = 1'b1;
                end
              end else begin
                nx.sout  = st.txSh[0];
                nx.txPar = st.txPar ^ st.txSh[0];
                nx.txSh  = {1'b0, st.txSh[7:1]};
                nx.txCnt = st.txCnt + 4'h1;
              end
            end
            PARITY: begin
              nx.sout = 1'b1;
              nx.txPh = STOP;
            end
            STOP: begin
              nx.txPh  = IDLE;
              nx.txRun = 1'b0;
              txDone   = 1'b1;
            end
            default: nx.txPh = IDLE;
          endcase
        end
      end
    end else begin
      nx.sout = 1'b1;
      nx.sclk = 1'b1;
      nx.txHalf = 1'b0;
    end
    // receiver timer: counts timer ticks on the timer source, else clocks
    rxTick = (st.parClk[1:0] == 2'h3) ? tmrTick : 1'b1;
    if (st.rxTmr != 20'h0 && rxTick) begin
      nx.rxTmr = st.rxTmr - 20'h1;
    end
    // receiver
    if (st.rxRun) begin
      case (st.rxPh)
        IDLE: begin
          if (asyncMode && !st.sin2) begin
            nx.rxPh  = START;
            nx.rxTmr = halfCount(st.parClk[1:0]);
          end else if (!asyncMode) begin
            nx.rxPh  = DATA;
            nx.rxCnt = 4'h0;
            nx.rxPar = st.parClk[BIT_PARSNS];
          end
        end
        START: begin
          if (st.rxTmr == 20'h0) begin
            nx.rxPh  = st.sin2 ? IDLE : DATA;
            nx.rxCnt = 4'h0;
            nx.rxPar = st.parClk[BIT_PARSNS];
            nx.rxTmr = {halfCount(st.parClk[1:0]) [18:0], 1'b0};
          end
        end
        DATA: begin
          if (asyncMode ? st.rxTmr == 20'h0 :
              (mode == MODE_SLAVE ? sckRise : (st.txRun && rateTick && st.txHalf))) begin
            nx.rxSh  = {st.sin2, st.rxSh[7:1]};
            nx.rxPar = st.rxPar ^ st.sin2;
            nx.rxCnt = st.rxCnt + 4'h1;
            nx.rxTmr = {halfCount(st.parClk[1:0]) [18:0], 1'b0};
            if (st.rxCnt == (bitCount8 ? 4'h7 : 4'h6)) begin
              nx.rxPh = !asyncMode ? STOP :
                        (st.parClk[BIT_PAREN] ? PARITY : STOP);
              if (!bitCount8) begin
                nx.rxSh = {1'b0, st.sin2, st.rxSh[7:2]};
              end
            end
          end
        end
        PARITY: begin
          if (st.rxTmr == 20'h0) begin
            parEv    = (st.rxPar ^ st.sin2);
            nx.rxPh  = STOP;
            nx.rxTmr = {halfCount(st.parClk[1:0]) [18:0], 1'b0};
          end
        end
        STOP: begin
          if (!asyncMode || st.rxTmr == 20'h0) begin
            frmEv     = asyncMode && !st.sin2;
            ovrEv     = st.rxUnread;
            nx.data   = st.rxSh;
            nx.rxUnread = 1'b1;
            nx.rxPh   = IDLE;
            nx.rxRun  = 1'b0;
            rxDone    = 1'b1;
          end
        end
        default: nx.rxPh = IDLE;
      endcase
    end
    // register writes
    if (doWr) begin
      nx.awHeld = 1'b0;
      nx.wHeld  = 1'b0;
      nx.bvalid = 1'b1;
      nx.bErr   = !isMapped(st.awAddr);
      if (wrLane) begin
        case (st.awAddr)
          ADDR_MODE:   nx.modeReg = {1'b0, wrNib[2:0]};
          ADDR_PARCLK: nx.parClk = wrNib;
          ADDR_TRIG: begin
            nx.transmit_enable = wrNib[BIT_TRANSMIT_ENABLE];
            nx.receive_enable = wrNib[BIT_RECEIVE_ENABLE];
            if (wrNib[BIT_TRANSMIT_TRIGGER] && wrNib[BIT_TRANSMIT_ENABLE] && !st.txRun) begin
              nx.txRun = 1'b1;
              nx.txPh  = START;
              nx.txSh  = st.data;
            end
            if (wrNib[BIT_RECEIVE_TRIGGER] && wrNib[BIT_RECEIVE_ENABLE] && !st.rxRun) begin
              nx.rxRun = 1'b1;
              nx.rxPh  = IDLE;
            end
          end
          ADDR_DATALO: nx.data[3:0] = wrNib;
          ADDR_DATAHI: nx.data[7:4] = wrNib;
          ADDR_TEST:   nx.testBit = wrNib[0];
          ADDR_IMASK:  nx.imask = {1'b0, wrNib[2:0]};
          ADDR_ERR:    nx.errs = st.errs & ~{1'b0, wrNib[2:0]};
          ADDR_IFLAG:  nx.iflag = st.iflag & ~{1'b0, wrNib[2:0]};
          default: ;
        endcase
      end
    end
    if (!nx.transmit_enable) begin
      nx.txRun = 1'b0;
      nx.txPh  = IDLE;
    end
    if (!nx.receive_enable) begin
      nx.rxRun = 1'b0;
      nx.rxPh  = IDLE;
    end
    if (frmEv) nx.errs[BIT_FRM] = 1'b1;
    if (parEv) nx.errs[BIT_PAR] = 1'b1;
    if (ovrEv) nx.errs[BIT_OVR] = 1'b1;
    if (frmEv || parEv || ovrEv) nx.iflag[BIT_ERREV] = 1'b1;
    if (txDone) nx.iflag[BIT_TXDONE] = 1'b1;
    if (rxDone) nx.iflag[BIT_RXDONE] = 1'b1;
    // register reads
    if (st.rvalid && s_axi_rready) begin
      nx.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !st.rvalid) begin
      nx.rvalid = 1'b1;
      nx.rErr   = !isMapped(s_axi_araddr);
      nx.rdata  = 32'h0;
      case (s_axi_araddr)
        ADDR_MODE:   nx.rdata[{s_axi_araddr[1:0], 3'h0} +: 4] = st.modeReg;
        ADDR_PARCLK: nx.rdata[{s_axi_araddr[1:0], 3'h0} +: 4] = st.parClk;
        ADDR_TRIG:   nx.rdata[{s_axi_araddr[1:0], 3'h0} +: 4] =
                       {st.rxRun, st.receive_enable, st.txRun, st.transmit_enable};
        ADDR_ERR:    nx.rdata[{s_axi_araddr[1:0], 3'h0} +: 4] = st.errs;
        ADDR_DATALO: begin
          nx.rdata[{s_axi_araddr[1:0], 3'h0} +: 4] = st.data[3:0];
          nx.rxUnread = 1'b0;
        end
        ADDR_DATAHI: begin
          nx.rdata[{s_axi_araddr[1:0], 3'h0} +: 4] = st.data[7:4];
          nx.rxUnread = 1'b0;
        end
        ADDR_TEST:   nx.rdata[{s_axi_araddr[1:0], 3'h0} +: 4] = {3'h0, st.testBit};
        ADDR_IMASK:  nx.rdata[{s_axi_araddr[1:0], 3'h0} +: 4] = st.imask;
        ADDR_IFLAG:  nx.rdata[{s_axi_araddr[1:0], 3'h0} +: 4] = st.iflag;
        default: ;
      endcase
      if (rxDone) nx.rxUnread = 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st      <= '0;
      st.sout <= 1'b1;
      st.sclk <= 1'b1;
      st.sin1 <= 1'b1;
      st.sin2 <= 1'b1;
    end else begin
      st <= nx;
    end
  end

  txDoneFlag_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(st.txRun) && st.transmit_enable |-> st.iflag[BIT_TXDONE])
    else $error("tx done flag not set");
  // interrupt ties to mask and flag
  irqMask_a: assert property (@(posedge clk) disable iff (!rst_n)
    irq == |(st.iflag[2:0] & st.imask[2:0]))
    else $error("irq mismatch");
  // framing flag sets only on stop error
  frmSet_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(st.errs[BIT_FRM]) |-> $past(frmEv))
    else $error("framing flag rose without cause");
  parSet_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(st.errs[BIT_PAR]) |-> $past(parEv) && $past(st.parClk[BIT_PAREN]))
    else $error("parity flag rose without cause");
  ovrSet_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(st.errs[BIT_OVR]) |-> $past(st.rxUnread))
    else $error("overrun without unread data");
  txGate_a: assert property (@(posedge clk) disable iff (!rst_n)
    st.txRun |-> st.transmit_enable)
    else $error("transmitter runs while disabled");
  rxGate_a: assert property (@(posedge clk) disable iff (!rst_n)
    st.rxRun |-> st.receive_enable)
    else $error("receiver runs while disabled");
  // idle line high when not sending
  idleHigh_a: assert property (@(posedge clk) disable iff (!rst_n)
    !st.txRun ##1 !st.txRun |-> serialOut)
    else $error("line not idle high");
endmodule : dual_mode_serial_interface

// *** serial_partner.sv ***
// behavioural asynchronous serial device on the far side of the channel
`timescale 1ns/1ps
module serial_partner #(
  parameter int BIT_NS = 640 // one bit time, two timer ticks
) (
  input  wire logic lineIn,   // data from the channel
  input  wire logic lineOe_n, // channel drives the line when low
  output logic      lineOut   // data towards the channel
);
  logic       withParity; // parity bit expected in captured frames
  logic [7:0] gotByte;    // last captured character
  logic       gotPar;     // its parity bit
  logic       gotStop;    // its stop bit
  int         gotCount;   // characters captured so far

  // idle line is high
  initial begin
    lineOut = 1'b1;
    withParity = 1'b0;
    gotCount = 0;
  end

  always @(negedge lineIn) begin
    if (lineOe_n === 1'b0) begin
      #(BIT_NS / 2);
      for (int i = 0; i < 8; i++) begin
        #(BIT_NS);
        gotByte[i] = lineIn;
      end
      gotPar = 1'b0;
      if (withParity) begin
        #(BIT_NS);
        gotPar = lineIn;
      end
      #(BIT_NS);
      gotStop = lineIn;
      gotCount++;
    end
  end

  // send one character, faults on request
  task automatic send(input logic [7:0] d, input logic par, input logic odd,
                      input logic badPar, input logic badStop);
    lineOut = 1'b0;
    #(BIT_NS);
    for (int i = 0; i < 8; i++) begin
      lineOut = d[i];
      #(BIT_NS);
    end
    if (par) begin
      lineOut = ^d ^ odd ^ badPar;
      #(BIT_NS);
    end
    lineOut = ~badStop;
    #(BIT_NS);
    lineOut = 1'b1;
    #(BIT_NS);
  endtask : send
endmodule : serial_partner

// *** dual_mode_serial_interface_tb.sv ***
// self-checking bench for the dual mode serial channel
`timescale 1ns/1ps
module dual_mode_serial_interface_tb;
  import serial_pkg::*;
  logic        clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, timerRate, sclkIn, serialIn;
  logic        serialOut, serialOutOe_n, sclkOut, sclkOe_n, pinsSerial, irq;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  int          failures, checkCount;

  dual_mode_serial_interface dual_mode_serial_interface_inst (
    .clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .timerRate(timerRate), .serialIn(serialIn), .serialOut(serialOut),
    .serialOutOe_n(serialOutOe_n), .sclkIn(sclkIn), .sclkOut(sclkOut),
    .sclkOe_n(sclkOe_n), .pinsSerial(pinsSerial), .irq(irq));

  serial_partner serial_partner_inst (
    .lineIn(serialOut), .lineOe_n(serialOutOe_n), .lineOut(serialIn));

  // core clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // free-running timer rate, unrelated phase
  initial begin
    timerRate = 1'b0;
    #7;
    forever #160 timerRate = ~timerRate;
  end

  // verdict and end of run
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checkCount, failures);
    if (failures == 0 && checkCount > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  // one comparison
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    checkCount++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %0h seen %0h", what, e, g);
    end
  endtask : chk

  // bound on every wait
  task automatic spin(inout int n);
    n++;
    if (n > 2000) begin
      failures++;
      $display("MISMATCH wait expected done seen timeout");
      tally_and_finish();
    end
  endtask : spin

  // bus write of one nibble in its byte lane
  task automatic wr(input logic [15:0] a, input logic [3:0] d);
    logic ta, tw, tb;
    int   n;
    n = 0;
    tb = 1'b0;
    awaddr <= a;
    wdata <= {28'h0, d} << (8 * a[1:0]);
    wstrb <= 4'h1 << a[1:0];
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!tb) begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid && bready;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      spin(n);
    end
  endtask : wr

  // bus read of one nibble
  task automatic rd(input logic [15:0] a, output logic [3:0] d, output logic [1:0] r);
    logic        ta, tr;
    logic [31:0] v;
    int          n;
    n = 0;
    tr = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    while (!tr) begin
      @(negedge clk);
      ta = arvalid && arready;
      tr = rvalid && rready;
      v = rdata;
      r = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
      spin(n);
    end
    d = 4'(v >> (8 * a[1:0]));
  endtask : rd

  // read and compare one register
  task automatic rc(input logic [15:0] a, input logic [3:0] e);
    logic [3:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk($sformatf("reg %h", a), e, d);
  endtask : rc

  // poll until a run bit drops
  task automatic wait_idle(input logic [15:0] a, input int b);
    logic [3:0] d;
    logic [1:0] r;
    int         n;
    n = 0;
    d = 4'hF;
    while (d[b] !== 1'b0) begin
      rd(a, d, r);
      spin(n);
    end
  endtask : wait_idle

  // reset values, data registers left alone, unmapped address
  task automatic reset_values();
    logic [15:0] regs [7];
    logic [3:0]  d;
    logic [1:0]  r;
    regs = '{ADDR_MODE, ADDR_PARCLK, ADDR_TRIG, ADDR_ERR, ADDR_TEST, ADDR_IMASK, ADDR_IFLAG};
    foreach (regs[i]) rc(regs[i], 4'h0);
    chk("irq", 0, irq);
    chk("serialOut", 1, serialOut);
    rd(16'hFF77, d, r);
    chk("unmapped resp", 2'h2, r);
  endtask : reset_values

  // every mode and rate code, pin hand-over
  task automatic mode_and_rate();
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_MODE, {1'b0, 2'(i), 1'b1});
      rc(ADDR_MODE, {1'b0, 2'(i), 1'b1});
      chk("pinsSerial", 1, pinsSerial);
      chk("sclkOe_n", i != 0, sclkOe_n);
      wr(ADDR_PARCLK, {2'b00, 2'(i)});
      rc(ADDR_PARCLK, {2'b00, 2'(i)});
    end
    wr(ADDR_MODE, 4'h6);
    chk("pinsSerial", 0, pinsSerial);
    chk("serialOutOe_n", 1, serialOutOe_n);
    wr(ADDR_MODE, 4'h7);
    wr(ADDR_TRIG, 4'hA);
    rc(ADDR_TRIG, 4'h0);
  endtask : mode_and_rate

  // transmit without parity, even, odd
  task automatic tx_frames();
    logic [7:0] d;
    int         n;
    wr(ADDR_IMASK, 4'h2);
    for (int k = 0; k < 3; k++) begin
      d = 8'hA5 ^ 8'(k);
      serial_partner_inst.withParity = (k != 0);
      wr(ADDR_PARCLK, {k != 0, k == 2, 2'h3});
      wr(ADDR_DATALO, d[3:0]);
      wr(ADDR_DATAHI, d[7:4]);
      n = serial_partner_inst.gotCount;
      wr(ADDR_TRIG, 4'h3);
      rc(ADDR_TRIG, 4'h3);
      wait_idle(ADDR_TRIG, 1);
      chk("tx byte", d, serial_partner_inst.gotByte);
      chk("tx parity", (k != 0) & (^d ^ (k == 2)), serial_partner_inst.gotPar);
      chk("tx stop", 1, serial_partner_inst.gotStop);
      chk("tx count", n + 1, serial_partner_inst.gotCount);
      chk("irq tx", 1, irq);
      rc(ADDR_IFLAG, 4'h2);
      wr(ADDR_IFLAG, 4'h2);
      chk("irq tx clear", 0, irq);
    end
  endtask : tx_frames

  // one received character and its error flags
  task automatic rx_frame(input logic [7:0] d, input logic bp, input logic bs,
                          input logic [3:0] e, input logic rdIt);
    logic [3:0] lo, hi;
    logic [1:0] r;
    wr(ADDR_TRIG, 4'hC);
    rc(ADDR_TRIG, 4'hC);
    fork
      serial_partner_inst.send(d, 1'b1, 1'b1, bp, bs);
      wait_idle(ADDR_TRIG, 3);
    join
    rc(ADDR_ERR, e);
    chk("irq err", e != 0, irq);
    wr(ADDR_ERR, 4'h0);
    rc(ADDR_ERR, e);
    wr(ADDR_ERR, 4'h7);
    rc(ADDR_ERR, 4'h0);
    if (e == 0) rc(ADDR_IFLAG, 4'h1);
    wr(ADDR_IFLAG, 4'h7);
    chk("irq clear", 0, irq);
    if (rdIt) begin
      rd(ADDR_DATALO, lo, r);
      rd(ADDR_DATAHI, hi, r);
      if (e == 0) chk("rx byte", d, {hi, lo});
    end
  endtask : rx_frame

  // stimulus and run order
  initial begin
    rst_n = 1'b0;
    {awvalid, wvalid, arvalid, awaddr, araddr, wdata, wstrb} = '0;
    bready = 1'b1;
    rready = 1'b1;
    sclkIn = 1'b1;
    failures = 0;
    checkCount = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    reset_values();
    mode_and_rate();
    tx_frames();
    wr(ADDR_PARCLK, 4'hF);
    wr(ADDR_IMASK, 4'h4);
    rx_frame(8'h3C, 1'b0, 1'b0, 4'h0, 1'b1);
    rx_frame(8'h5A, 1'b1, 1'b0, 4'h2, 1'b1);
    rx_frame(8'hC3, 1'b0, 1'b1, 4'h4, 1'b1);
    rx_frame(8'h81, 1'b0, 1'b0, 4'h0, 1'b0);
    rx_frame(8'h7E, 1'b0, 1'b0, 4'h1, 1'b1);
    tally_and_finish();
  end
endmodule : dual_mode_serial_interface_tb
